// *** hw/phrp_device.sv ***
/*
 * phrp_device: register end of the parallel host port, with a small
 * register file, alarm interrupt and the four bus conventions.
 * assumes: proc_clk runs only in synchronous modes; the style selects
 * are static; alarm is synchronous to clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - 4-bit address, 8-bit shared data bus
// - two static selects choose bus convention
// - host clocks sync modes; clock low otherwise
// - latch style: address taken at latch fall
// - strobe style: address taken at strobe fall
// - read, write and data strobes ignored while chip select high
// - latch style: read strobe low starts read
// - latch style: write strobe low starts write
// - strobe style: data strobe marks access
// - strobe style: direction from read-not-write
// - latch style: done driven high when complete
// - strobe style: acknowledge driven low when complete
// - alarm raises interrupt unless enable blocks
// - control 0 bit 1 enables interrupts
module phrp_device #(
    parameter int REGS = phrp_pkg::PHRP_REG_COUNT
) (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       alarm,
    output logic [7:0]      ctrl0,
    phrp_link_if.dev        lnk
);
    localparam int SHI = phrp_pkg::PHRP_PIN_SEL_HI;
    localparam int SLO = phrp_pkg::PHRP_PIN_SEL_LO;
    localparam int CSL = phrp_pkg::PHRP_PIN_CSEL;
    localparam int ACP = phrp_pkg::PHRP_PIN_ACAP;
    localparam int RDS = phrp_pkg::PHRP_PIN_RDS;
    localparam int WRN = phrp_pkg::PHRP_PIN_WRN;
    localparam int ALS = phrp_pkg::PHRP_PIN_ADDR_LSB;
    localparam int DLS = phrp_pkg::PHRP_PIN_DATA_LSB;
    localparam int AW  = phrp_pkg::PHRP_ADDR_W;
    localparam int DW  = phrp_pkg::PHRP_DATA_W;
    localparam int PW  = phrp_pkg::PHRP_PIN_W;

    typedef struct packed {
        logic [PW-1:0]          s1;
        logic [PW-1:0]          s2;
        logic [PW-1:0]          s3;
        logic [PW-1:0]          f;
        logic [AW-1:0]          addr;
        logic [REGS-1:0][DW-1:0] regs;
        logic [DW-1:0]          rdata;
        logic                   act;
        logic                   done;
        logic                   drive;
        logic                   irq_n;
        logic                   rq1;
        logic                   rq2;
        logic                   rseen;
        logic                   ack;
    } phrp_sys_t;

    typedef struct packed {
        logic [PW-1:0]          r;
        logic [AW-1:0]          addr;
        logic [DW-1:0]          wdata;
        logic [DW-1:0]          rdata;
        logic                   rd;
        logic                   req;
        logic                   busy;
        logic                   done;
        logic                   drive;
        logic                   a1;
        logic                   a2;
        logic                   aseen;
    } phrp_lnk_t;

    phrp_sys_t     q;
    phrp_sys_t     n;
    phrp_lnk_t     p;
    phrp_lnk_t     m;
    logic [PW-1:0] pins;
    logic          done_lvl;

    assign pins = {lnk.bus_style_select_high, lnk.bus_style_select_low,
                   lnk.chip_select_n, lnk.address_capture_strobe,
                   lnk.read_or_data_strobe_n, lnk.write_or_rnw,
                   lnk.addr, lnk.data};

    // clk_sys side: register file, asynchronous modes, interrupt
    always_comb begin
        logic [1:0]    dec;
        logic          acc;
        logic          acc_wr;
        logic [AW-1:0] acc_a;
        logic [DW-1:0] acc_d;
        n      = q;
        dec    = 2'h0;
        acc    = 1'h0;
        acc_wr = 1'h0;
        acc_a  = q.addr;
        acc_d  = 8'h00;
        n.s1   = pins;
        n.s2   = q.s1;
        n.s3   = q.s2;
        // a pin change counts once stages two and three agree
        n.f    = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.f);
        dec    = phrp_pkg::phrp_decode(n.f[SLO], n.f[CSL],
                                       n.f[RDS], n.f[WRN]);
        if (!n.f[SHI]) begin
            if (q.f[ACP] && !n.f[ACP]) begin
                n.addr = n.f[ALS +: AW];
            end
            n.act   = dec[1];
            n.drive = dec[1] && dec[0];
            if (dec[1] && !q.act) begin
                acc    = 1'h1;
                acc_wr = !dec[0];
                acc_a  = q.addr;
                acc_d  = n.f[DLS +: DW];
                n.done = 1'h1;
            end else if (!dec[1]) begin
                n.done = 1'h0;
            end
        end else begin
            n.act   = 1'h0;
            n.done  = 1'h0;
            n.drive = 1'h0;
        end
        // synchronous-mode requests arrive by toggle from proc_clk side
        n.rq1 = p.req;
        n.rq2 = q.rq1;
        if (q.rq2 != q.rseen) begin
            n.rseen = q.rq2;
            n.ack   = !q.ack;
            acc     = 1'h1;
            acc_wr  = !p.rd;
            acc_a   = p.addr;
            acc_d   = p.wdata;
        end
        if (acc) begin
            // addresses past the file read zero, writes dropped
            n.rdata = 8'h00;
            if (int'(acc_a) < REGS) begin
                n.rdata = q.regs[acc_a];
                if (acc_wr) begin
                    n.regs[acc_a] = acc_d;
                end
            end
        end
        n.irq_n = !(alarm &&
                    q.regs[phrp_pkg::PHRP_CTRL0_ADDR]
                          [phrp_pkg::PHRP_GIE_BIT]);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q       <= '0;
            q.s1    <= phrp_pkg::PHRP_PIN_IDLE;
            q.s2    <= phrp_pkg::PHRP_PIN_IDLE;
            q.s3    <= phrp_pkg::PHRP_PIN_IDLE;
            q.f     <= phrp_pkg::PHRP_PIN_IDLE;
            q.regs  <= {REGS{phrp_pkg::PHRP_REG_RESET}};
            q.irq_n <= 1'h1;
        end else begin
            q <= n;
        end
    end

    // proc_clk side: pins taken straight on the rising edge, since the
    // host changes them half a period away from it
    always_comb begin
        logic [1:0] dec;
        m     = p;
        dec   = 2'h0;
        m.r   = pins;
        m.a1  = q.ack;
        m.a2  = p.a1;
        dec   = phrp_pkg::phrp_decode(pins[SLO], pins[CSL],
                                      pins[RDS], pins[WRN]);
        if (pins[SHI]) begin
            if (p.r[ACP] && !pins[ACP]) begin
                m.addr = pins[ALS +: AW];
            end
            if (dec[1] && !p.busy && !p.done) begin
                m.wdata = pins[DLS +: DW];
                m.rd    = dec[0];
                m.req   = !p.req;
                m.busy  = 1'h1;
            end
            if (p.busy && (p.a2 != p.aseen)) begin
                m.aseen = p.a2;
                m.busy  = 1'h0;
                m.done  = 1'h1;
                m.rdata = q.rdata;
            end else if (!dec[1] && !p.busy) begin
                m.done = 1'h0;
            end
            m.drive = dec[1] && dec[0];
        end else begin
            m.done  = 1'h0;
            m.drive = 1'h0;
        end
    end

    always_ff @(posedge lnk.proc_clk or negedge resetn) begin
        if (!resetn) begin
            p   <= '0;
            p.r <= phrp_pkg::PHRP_PIN_IDLE;
        end else begin
            p <= m;
        end
    end

    // mode is static, so picking between domains does not glitch
    assign done_lvl = q.f[SHI] ? p.done : q.done;
    assign lnk.access_done = q.f[SLO] ? !done_lvl : done_lvl;
    assign lnk.data_d      = q.f[SHI] ? p.rdata : q.rdata;
    assign lnk.data_d_oe   = q.f[SHI] ? p.drive : q.drive;
    assign lnk.irq_n       = q.irq_n;
    assign ctrl0           = q.regs[phrp_pkg::PHRP_CTRL0_ADDR];
endmodule

`default_nettype wire

// *** hw/phrp_host.sv ***
/*
 * phrp_host: processor end of the parallel host port; turns one
 * command at a time into a bus access of the selected convention.
 * assumes: style selects are static while commands run.
 */
`timescale 1ns/10ps
`default_nettype none

module phrp_host #(
    parameter int HALF = phrp_pkg::PHRP_PCLK_HALF
) (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       style_low,
    input  wire logic       style_high,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic       cmd_write,
    input  wire logic [3:0] cmd_addr,
    input  wire logic [7:0] cmd_wdata,
    output logic            rsp_valid,
    output logic [7:0]      rsp_rdata,
    output logic            irq_n,
    phrp_link_if.host       lnk
);
    localparam int HW = phrp_pkg::PHRP_HV_W;

    typedef enum logic [2:0] {
        PHRP_H_IDLE    = 3'b000,
        PHRP_H_ADDR    = 3'b001,
        PHRP_H_LATCH   = 3'b010,
        PHRP_H_STROBE  = 3'b011,
        PHRP_H_RECOVER = 3'b100,
        PHRP_H_WAIT    = 3'b101
    } phrp_hstate_t;

    typedef struct packed {
        logic [7:0]    div;
        logic          ph;
        logic [HW-1:0] s1;
        logic [HW-1:0] s2;
        logic [HW-1:0] s3;
        logic [HW-1:0] f;
        phrp_hstate_t  st;
        logic          wr;
        logic [3:0]    addr;
        logic [7:0]    wdata;
        logic [7:0]    rdata;
        logic          rsp;
    } phrp_host_t;

    phrp_host_t q;
    phrp_host_t n;
    logic       tick;
    logic       done;
    logic       strobing;

    // strobe pins change on the falling edge of the processor clock
    assign tick = q.ph && (q.div == 8'(HALF - 1));
    assign done = style_low ? !q.f[phrp_pkg::PHRP_HV_DONE]
                            : q.f[phrp_pkg::PHRP_HV_DONE];

    always_comb begin
        n    = q;
        n.rsp = 1'h0;
        n.div = q.div + 8'h01;
        if (q.div == 8'(HALF - 1)) begin
            n.div = 8'h00;
            n.ph  = !q.ph;
        end
        n.s1 = {lnk.irq_n, lnk.access_done, lnk.data};
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.f  = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.f);
        unique case (q.st)
            PHRP_H_IDLE: begin
                if (cmd_valid) begin
                    n.wr    = cmd_write;
                    n.addr  = cmd_addr;
                    n.wdata = cmd_wdata;
                    n.st    = PHRP_H_WAIT;
                end
            end
            // strobes move only on a tick, so a sync device never
            // races a pin change and async pulses outlast the filter
            PHRP_H_WAIT: begin
                if (tick) n.st = PHRP_H_ADDR;
            end
            PHRP_H_ADDR: begin
                if (tick) n.st = PHRP_H_LATCH;
            end
            PHRP_H_LATCH: begin
                if (tick) n.st = PHRP_H_STROBE;
            end
            PHRP_H_STROBE: begin
                if (tick && done) begin
                    n.rdata = q.f[7:0];
                    n.rsp   = 1'h1;
                    n.st    = PHRP_H_RECOVER;
                end
            end
            PHRP_H_RECOVER: begin
                if (tick && !done) n.st = PHRP_H_IDLE;
            end
            default: n.st = PHRP_H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q    <= '0;
            q.s1 <= phrp_pkg::PHRP_HV_IDLE;
            q.s2 <= phrp_pkg::PHRP_HV_IDLE;
            q.s3 <= phrp_pkg::PHRP_HV_IDLE;
            q.f  <= phrp_pkg::PHRP_HV_IDLE;
            q.st <= PHRP_H_IDLE;
        end else begin
            q <= n;
        end
    end

    assign strobing  = (q.st == PHRP_H_STROBE);
    assign cmd_ready = (q.st == PHRP_H_IDLE);
    assign rsp_valid = q.rsp;
    assign rsp_rdata = q.rdata;
    assign irq_n     = q.f[phrp_pkg::PHRP_HV_IRQ];

    assign lnk.proc_clk_drv          = style_high && q.ph;
    assign lnk.bus_style_select_low  = style_low;
    assign lnk.bus_style_select_high = style_high;
    assign lnk.addr                  = q.addr;
    // latch style idles low; strobe style idles high outside an access
    assign lnk.address_capture_strobe =
        (q.st == PHRP_H_ADDR) ||
        (style_low && (q.st == PHRP_H_IDLE || q.st == PHRP_H_WAIT ||
                       q.st == PHRP_H_RECOVER));
    assign lnk.chip_select_n         = !strobing;
    assign lnk.read_or_data_strobe_n =
        !(strobing && (style_low || !q.wr));
    assign lnk.write_or_rnw          =
        style_low ? !q.wr : !(strobing && q.wr);
    assign lnk.data_h                = q.wdata;
    assign lnk.data_h_oe             = strobing && q.wr;
endmodule

`default_nettype wire

// *** hw/phrp_link_if.sv ***
/*
 * phrp_link_if: pins between host processor and the register port.
 * assumes: host makes the processor clock; the testbench joins the ends.
 */
`timescale 1ns/10ps
`default_nettype none

interface phrp_link_if;
    logic       proc_clk_drv;
    logic       proc_clk;
    logic       bus_style_select_low;
    logic       bus_style_select_high;
    logic [3:0] addr;
    logic       address_capture_strobe;
    logic       chip_select_n;
    logic       read_or_data_strobe_n;
    logic       write_or_rnw;
    logic [7:0] data_h;
    logic       data_h_oe;
    logic [7:0] data_d;
    logic       data_d_oe;
    logic [7:0] data;
    logic       access_done;
    logic       irq_n;

    // pull-down stand-in: clock is low in asynchronous modes
    assign proc_clk = bus_style_select_high ? proc_clk_drv : 1'h0;
    // shared bus; undriven reads as zero
    assign data = data_h_oe ? data_h : (data_d_oe ? data_d : 8'h00);

    modport host (
        output proc_clk_drv,
        output bus_style_select_low,
        output bus_style_select_high,
        output addr,
        output address_capture_strobe,
        output chip_select_n,
        output read_or_data_strobe_n,
        output write_or_rnw,
        output data_h,
        output data_h_oe,
        input  data,
        input  access_done,
        input  irq_n
    );

    modport dev (
        input  proc_clk,
        input  bus_style_select_low,
        input  bus_style_select_high,
        input  addr,
        input  address_capture_strobe,
        input  chip_select_n,
        input  read_or_data_strobe_n,
        input  write_or_rnw,
        input  data,
        output data_d,
        output data_d_oe,
        output access_done,
        output irq_n
    );
endinterface

`default_nettype wire

// *** hw/phrp_pkg.sv ***
/*
 * phrp_pkg: constants, pin layout and strobe decode shared by both ends
 * of the parallel host register port.
 * assumes: both ends see clk_sys at 250 MHz.
 */
`default_nettype none

package phrp_pkg;
    localparam int PHRP_CLK_SYS_MHZ  = 250;
    localparam int PHRP_PCLK_MAX_MHZ = 33;
    // half period of the processor clock in clk_sys cycles, rounded up
    localparam int PHRP_PCLK_HALF    =
        (PHRP_CLK_SYS_MHZ + 2 * PHRP_PCLK_MAX_MHZ - 1)
        / (2 * PHRP_PCLK_MAX_MHZ);
    localparam int PHRP_ADDR_W       = 4;
    localparam int PHRP_DATA_W       = 8;
    localparam int PHRP_REG_COUNT    = 14;
    localparam logic [3:0] PHRP_CTRL0_ADDR = 4'h0;
    localparam int PHRP_GIE_BIT      = 1;
    localparam logic [7:0] PHRP_REG_RESET  = 8'h00;

    // device-side pin vector layout
    localparam int PHRP_PIN_W        = 18;
    localparam int PHRP_PIN_SEL_HI   = 17;
    localparam int PHRP_PIN_SEL_LO   = 16;
    localparam int PHRP_PIN_CSEL     = 15;
    localparam int PHRP_PIN_ACAP     = 14;
    localparam int PHRP_PIN_RDS      = 13;
    localparam int PHRP_PIN_WRN      = 12;
    localparam int PHRP_PIN_ADDR_LSB = 8;
    localparam int PHRP_PIN_DATA_LSB = 0;
    // deselected, strobes high, capture strobe low
    localparam logic [17:0] PHRP_PIN_IDLE = 18'h0B000;

    // host-side sampled vector layout
    localparam int PHRP_HV_W         = 10;
    localparam int PHRP_HV_IRQ       = 9;
    localparam int PHRP_HV_DONE      = 8;
    localparam logic [9:0] PHRP_HV_IDLE = 10'h200;

    // {select_high, select_low}: high bit = synchronous, low = strobe style
    typedef enum logic [1:0] {
        PHRP_ASYNC_LATCH  = 2'b00,
        PHRP_ASYNC_STROBE = 2'b01,
        PHRP_SYNC_LATCH   = 2'b10,
        PHRP_SYNC_STROBE  = 2'b11
    } phrp_mode_t;

    // returns {access active, access is a read}
    function automatic logic [1:0] phrp_decode(
        input logic strobe_style,
        input logic csel_n,
        input logic rds_n,
        input logic wrn
    );
        logic act;
        logic rd;
        if (strobe_style) begin
            act = !csel_n && !rds_n;
            rd  = wrn;
        end else begin
            act = !csel_n && (!rds_n || !wrn);
            rd  = !rds_n;
        end
        return {act, rd};
    endfunction
endpackage

`default_nettype wire

// *** verification/parallel_host_register_port_test.sv ***
/*
 * parallel_host_register_port_test: host end against device end in all
 * four bus styles, plus a bench-driven device for chip select faults.
 * assumes: hw/ package, interface and both ends compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHK(what, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
            err_total++; \
        end \
    end

module parallel_host_register_port_test;
    logic       clk_sys;
    logic       resetn;
    logic       alarm;
    logic       style_low;
    logic       style_high;
    logic       cmd_valid;
    logic       cmd_write;
    logic [3:0] cmd_addr;
    logic [7:0] cmd_wdata;
    logic       cmd_ready;
    logic       rsp_valid;
    logic [7:0] rsp_rdata;
    logic       irq_n;
    logic [7:0] ctrl0;
    logic [7:0] ctrl0_b;
    logic [7:0] rd;
    int         err_total;
    int         total_checks;
    int         cycles;

    phrp_link_if lnk ();
    phrp_link_if lnk_b ();

    phrp_host i_phrp_host (
        .clk_sys(clk_sys), .resetn(resetn), .style_low(style_low),
        .style_high(style_high), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .irq_n(irq_n), .lnk(lnk)
    );
    phrp_device i_phrp_device (
        .clk_sys(clk_sys), .resetn(resetn), .alarm(alarm),
        .ctrl0(ctrl0), .lnk(lnk)
    );
    // second device, its pins driven by hand to break the host rules
    phrp_device i_phrp_device_b (
        .clk_sys(clk_sys), .resetn(resetn), .alarm(1'h0),
        .ctrl0(ctrl0_b), .lnk(lnk_b)
    );
    phrp_link_sva i_phrp_link_sva (
        .clk_sys(clk_sys), .resetn(resetn), .proc_clk(lnk.proc_clk),
        .proc_clk_drv(lnk.proc_clk_drv),
        .bus_style_select_low(lnk.bus_style_select_low),
        .bus_style_select_high(lnk.bus_style_select_high),
        .addr(lnk.addr),
        .address_capture_strobe(lnk.address_capture_strobe),
        .chip_select_n(lnk.chip_select_n),
        .read_or_data_strobe_n(lnk.read_or_data_strobe_n),
        .write_or_rnw(lnk.write_or_rnw), .data_h_oe(lnk.data_h_oe),
        .data_d_oe(lnk.data_d_oe), .access_done(lnk.access_done)
    );

    initial begin
        clk_sys = 1'h0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic wrap_up();
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // styles change only under reset, as they are static pins
    task automatic do_reset(input logic [1:0] mode);
        resetn = 1'h0;
        style_high = mode[1];
        style_low = mode[0];
        tick(8);
        resetn = 1'h1;
        tick(8);
    endtask

    task automatic access(input logic wr, input logic [3:0] a,
                          input logic [7:0] wd);
        int n;
        n = 0;
        while (cmd_ready !== 1'h1 && n < 2000) begin
            tick(1);
            n++;
        end
        cmd_valid = 1'h1;
        cmd_write = wr;
        cmd_addr = a;
        cmd_wdata = wd;
        tick(1);
        cmd_valid = 1'h0;
        n = 0;
        while (rsp_valid !== 1'h1 && n < 2000) begin
            tick(1);
            n++;
        end
        rd = rsp_rdata;
        `CHK("response", 1'h1, rsp_valid);
    endtask

    task automatic t_mode(input logic [1:0] mode);
        do_reset(mode);
        `CHK("ctrl0 reset", 8'h00, ctrl0);
        access(1'h1, 4'h0, 8'hA5);
        `CHK("ctrl0 write", 8'hA5, ctrl0);
        access(1'h0, 4'h0, 8'h00);
        `CHK("read reg0", 8'hA5, rd);
        access(1'h1, 4'hD, 8'h3C);
        access(1'h0, 4'hD, 8'h00);
        `CHK("read reg13", 8'h3C, rd);
        access(1'h0, 4'hC, 8'h00);
        `CHK("read reg12", 8'h00, rd);
        access(1'h1, 4'hE, 8'hFF);
        access(1'h0, 4'hE, 8'h00);
        `CHK("read reg14", 8'h00, rd);
        `CHK("ctrl0 kept", 8'hA5, ctrl0);
    endtask

    task automatic irq_is(input logic exp);
        tick(40);
        `CHK("host irq", exp, irq_n);
        `CHK("link irq", exp, lnk.irq_n);
    endtask

    task automatic t_irq();
        do_reset(2'h0);
        alarm = 1'h1;
        irq_is(1'h1);
        access(1'h1, 4'h0, 8'h02);
        irq_is(1'h0);
        alarm = 1'h0;
        irq_is(1'h1);
        alarm = 1'h1;
        irq_is(1'h0);
        access(1'h1, 4'h0, 8'h00);
        irq_is(1'h1);
        alarm = 1'h0;
    endtask

    task automatic t_cs_high();
        int n;
        lnk_b.address_capture_strobe = 1'h1;
        tick(8);
        lnk_b.address_capture_strobe = 1'h0;
        lnk_b.data_h = 8'hFF;
        lnk_b.data_h_oe = 1'h1;
        tick(8);
        lnk_b.write_or_rnw = 1'h0;
        tick(24);
        `CHK("done deselected", 1'h0, lnk_b.access_done);
        `CHK("ctrl0 deselected", 8'h00, ctrl0_b);
        lnk_b.chip_select_n = 1'h0;
        n = 0;
        while (lnk_b.access_done !== 1'h1 && n < 100) begin
            tick(1);
            n++;
        end
        `CHK("done selected", 1'h1, lnk_b.access_done);
        `CHK("ctrl0 selected", 8'hFF, ctrl0_b);
        lnk_b.write_or_rnw = 1'h1;
        lnk_b.chip_select_n = 1'h1;
        lnk_b.data_h_oe = 1'h0;
        tick(12);
        `CHK("done released", 1'h0, lnk_b.access_done);
    endtask

    initial begin
        err_total = 0;
        total_checks = 0;
        cycles = 0;
        resetn = 1'h0;
        alarm = 1'h0;
        style_low = 1'h0;
        style_high = 1'h0;
        cmd_valid = 1'h0;
        cmd_write = 1'h0;
        cmd_addr = 4'h0;
        cmd_wdata = 8'h00;
        lnk_b.proc_clk_drv = 1'h0;
        lnk_b.bus_style_select_low = 1'h0;
        lnk_b.bus_style_select_high = 1'h0;
        lnk_b.addr = 4'h0;
        lnk_b.address_capture_strobe = 1'h0;
        lnk_b.chip_select_n = 1'h1;
        lnk_b.read_or_data_strobe_n = 1'h1;
        lnk_b.write_or_rnw = 1'h1;
        lnk_b.data_h = 8'h00;
        lnk_b.data_h_oe = 1'h0;
        tick(1);
        for (int m = 0; m < 4; m++) begin
            t_mode(m[1:0]);
        end
        t_irq();
        t_cs_high();
        wrap_up();
    end
endmodule

`default_nettype wire

// *** verification/phrp_link_sva.sv ***
/*
 * phrp_link_sva: timing checks on the pins between the two ends.
 * assumes: sampled on clk_sys; proc_clk is divided down from clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none

module phrp_link_sva (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       proc_clk,
    input  wire logic       proc_clk_drv,
    input  wire logic       bus_style_select_low,
    input  wire logic       bus_style_select_high,
    input  wire logic [3:0] addr,
    input  wire logic       address_capture_strobe,
    input  wire logic       chip_select_n,
    input  wire logic       read_or_data_strobe_n,
    input  wire logic       write_or_rnw,
    input  wire logic       data_h_oe,
    input  wire logic       data_d_oe,
    input  wire logic       access_done
);
    logic [5:0] cs_high_q;
    logic       done_act;

    // done polarity follows the strobe style
    assign done_act = access_done != bus_style_select_low;

    // sync release comes at the next proc_clk rise, half a period after chip select rises; the margin is long
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cs_high_q <= 6'h00;
        end else if (!chip_select_n) begin
            cs_high_q <= 6'h00;
        end else if (cs_high_q != 6'h3F) begin
            cs_high_q <= cs_high_q + 6'h01;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    property p_idle_no_drive;
        cs_high_q >= 6'h28 |-> !data_d_oe;
    endproperty
    property p_idle_no_done;
        cs_high_q >= 6'h28 |-> !done_act;
    endproperty
    property p_done_needs_cs;
        $rose(done_act) |-> !chip_select_n;
    endproperty
    property p_no_contention;
        data_d_oe |-> !data_h_oe;
    endproperty
    property p_clk_low_async;
        !bus_style_select_high |-> !proc_clk_drv;
    endproperty
    property p_clk_high_phase;
        $rose(proc_clk) |-> proc_clk [*4];
    endproperty
    property p_sync_pins_on_fall;
        bus_style_select_high && $changed(chip_select_n) |-> !proc_clk;
    endproperty
    property p_addr_held;
        !chip_select_n |-> $stable(addr);
    endproperty
    property p_latched_first;
        $fell(chip_select_n) |-> !address_capture_strobe;
    endproperty
    property p_write_drives;
        !chip_select_n && !write_or_rnw
            && (!bus_style_select_low || !read_or_data_strobe_n)
            |-> data_h_oe;
    endproperty

    a_idle_no_drive: assert property (p_idle_no_drive)
        else $error("device drives data while deselected");
    a_idle_no_done: assert property (p_idle_no_done)
        else $error("done active while deselected");
    a_done_needs_cs: assert property (p_done_needs_cs)
        else $error("done raised without chip select");
    a_no_contention: assert property (p_no_contention)
        else $error("both ends drive the data bus");
    a_clk_low_async: assert property (p_clk_low_async)
        else $error("processor clock runs in async mode");
    a_clk_high_phase: assert property (p_clk_high_phase)
        else $error("processor clock high phase too short");
    a_sync_pins_on_fall: assert property (p_sync_pins_on_fall)
        else $error("chip select moved while proc clock high");
    a_addr_held: assert property (p_addr_held)
        else $error("address moved during access");
    a_latched_first: assert property (p_latched_first)
        else $error("capture strobe high at access start");
    a_write_drives: assert property (p_write_drives)
        else $error("host not driving data on write");

    c_read_drive: cover property ($rose(data_d_oe));
    c_sync_done: cover property ($rose(done_act) && bus_style_select_high);
    c_proc_clk: cover property ($rose(proc_clk));
endmodule

`default_nettype wire
